// ---- design/intc_pkg.sv ----
package intc_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] REQ_LOW_ADDR    = 8'h00ED;  // request_flags_low
  localparam logic [7:0] TIMER_SRC_ADDR  = 8'h00EE;  // timer_source_flags
  localparam logic [7:0] PERIPH_SRC_ADDR = 8'h00EF;  // peripheral_source_flags
  localparam logic [7:0] ENABLE_LOW_ADDR = 8'h00EB;  // per-source enables, low group
  localparam logic [7:0] REG_RESET       = 8'h0000;  // every flag register clears to zero

  // ***************************************************************
  // field layout
  // ***************************************************************
  localparam logic [7:0] REQ_LOW_MASK    = 8'h00FD;  // bit 1 unused
  localparam logic [7:0] PERIPH_SRC_MASK = 8'h0083;  // bits 6..2 unused
  localparam int         BIT_TWO_WIRE    = 7;
  localparam int         BIT_UART_RX     = 1;
  localparam int         BIT_UART_TX     = 0;

  // ***************************************************************
  // vector table, lowest priority bit first
  // ***************************************************************
  localparam logic [15:0] VEC_BASE  = 16'hFFE0;  // basic timer entry
  localparam logic [15:0] VEC_NMI   = 16'hFFFE;  // non-maskable entry
  localparam logic [7:0]  PSW_IFLAG = 8'h0004;   // master enable bit mask

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS    = 100;
  localparam int ACCEPT_CYCLES    = 8;  // in main oscillator cycles
  localparam logic [3:0] ACCEPT_LAST = 4'(ACCEPT_CYCLES - 1);

  // acceptance sequencer, one state per bus cycle
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_UNUSED = 4'b0001,
    ST_PUSH_H = 4'b0010,
    ST_PUSH_L = 4'b0011,
    ST_PUSH_P = 4'b0100,
    ST_VEC_L  = 4'b0101,
    ST_VEC_H  = 4'b0110,
    ST_ENTRY  = 4'b0111,
    ST_FETCH  = 4'b1000
  } accept_state_t;

endpackage : intc_pkg

// ---- design/interrupt_request_and_acceptance.sv ----
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// R1 - low request flags, seven sources, reset zero
// R2 - flag reads pending; writing zero clears
// R3 - timer match/overflow seen flags, four timers
// R4 - peripheral seen flags: two-wire, uart rx/tx
// R5 - seen flags survive vectoring for software
// R6 - request latched until accepted or cleared
// R7 - acceptance takes eight oscillator cycles
// R8 - return instruction ends service, restores state
// R9 - acceptance clears master enable flag
// R10 - non-maskable acceptance blocks later interrupts
// R11 - accepted source flag cleared, others kept
// R12 - push pc high, low, status; sp-3
// R13 - load vector entry into pc, execute
// R14 - bus order: idle, pushes, vector, fetch
// R15 - master enable zero blocks all maskables
// R16 - software sets enable for nesting
// R17 - only status and return address saved
// R18 - per-source enable zero blocks source
// R19 - higher fixed priority serviced first
// R20 - software clears shared uart seen flags
// R21 - set beats simultaneous clear
// R22 - start only at boundary with enabled request
module interrupt_request_and_acceptance
  import intc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  source_event,
  input  wire logic [7:0]  timer_event,
  input  wire logic [7:0]  periph_event,
  input  wire logic        nmi_event,
  input  wire logic        insn_boundary,
  input  wire logic        iflag,
  input  wire logic        return_from_interrupt_done,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  psw_in,
  input  wire logic [7:0]  sp_in,
  input  wire logic [7:0]  bus_rdata,
  output logic             accept_busy,
  output logic             iflag_clear,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic      [15:0] bus_addr,
  output logic      [7:0]  bus_wdata,
  output logic             sp_dec,
  output logic             pc_load,
  output logic      [15:0] pc_out
);

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic [1:0] rst_sync_q;  // two-stage release
  logic       rst_n;       // synchronised reset

  // release through two flops so all flops leave reset together
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0]    req_low_q;       // pending requests
  logic [7:0]    timer_src_q;     // timer seen flags
  logic [7:0]    periph_src_q;    // peripheral seen flags
  logic [7:0]    enable_low_q;    // per-source enables
  logic          nmi_pend_q;      // pending non-maskable
  logic          nmi_block_q;     // blocks all after nmi
  accept_state_t state_q;         // sequencer state
  logic [2:0]    accept_idx_q;    // accepted source bit
  logic          accept_nmi_q;    // accepting the nmi
  logic [7:0]    entry_low_q;     // fetched entry low byte
  logic [7:0]    entry_high_q;    // fetched entry high byte
  logic [7:0]    clr_mask;        // flag cleared by acceptance
  logic [7:0]    eligible;        // enabled pending sources
  logic          start;           // sequencer launch
  logic [2:0]    win_idx;         // winning source
  logic          wr_req, wr_tim, wr_per, wr_en;

  // pick highest set bit: higher bit means higher priority here
  function automatic logic [2:0] top_bit(input logic [7:0] v);
    logic [2:0] r;
    r = 3'd0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : top_bit

  // one decode shared by every register write
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic w);
    return w && (a == b);
  endfunction : hit

  assign wr_req = hit(reg_addr, REQ_LOW_ADDR, reg_wr);
  assign wr_tim = hit(reg_addr, TIMER_SRC_ADDR, reg_wr);
  assign wr_per = hit(reg_addr, PERIPH_SRC_ADDR, reg_wr);
  assign wr_en  = hit(reg_addr, ENABLE_LOW_ADDR, reg_wr);

  // ***************************************************************
  // request flags
  // ***************************************************************
  // acceptance clears only the source it vectors to
  always_comb begin
    clr_mask = 8'h0000;
    if (state_q == ST_UNUSED && !accept_nmi_q) begin
      // R11 - clear accepted flag
      clr_mask[accept_idx_q] = 1'b1;
    end
  end

  // R1 - low request flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_low_q <= REG_RESET;
    end else if (clk_en) begin
      // R6 - latched until accepted, written or reset
      // R2 - software zero clears; R21 - event wins
      req_low_q <= (((wr_req ? (req_low_q & reg_wdata) : req_low_q) & ~clr_mask)
                    | source_event) & REQ_LOW_MASK;
    end
  end

  // R3 - timer seen flags; R5 - only software clears them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_src_q <= REG_RESET;
    end else if (clk_en) begin
      // R21 - event wins over clear
      timer_src_q <= (wr_tim ? (timer_src_q & reg_wdata) : timer_src_q) | timer_event;
    end
  end

  // R4 - peripheral seen flags; R20 - software clears shared uart flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_src_q <= REG_RESET;
    end else if (clk_en) begin
      periph_src_q <= ((wr_per ? (periph_src_q & reg_wdata) : periph_src_q)
                       | periph_event) & PERIPH_SRC_MASK;
    end
  end

  // enables are plain storage, gating acceptance
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_low_q <= REG_RESET;
    end else if (clk_en && wr_en) begin
      enable_low_q <= reg_wdata & REQ_LOW_MASK;
    end
  end

  // read data stand one cycle after the strobe, unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h0000;
    end else if (clk_en) begin
      reg_rdata <= 8'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          REQ_LOW_ADDR:    reg_rdata <= req_low_q;
          TIMER_SRC_ADDR:  reg_rdata <= timer_src_q;
          PERIPH_SRC_ADDR: reg_rdata <= periph_src_q;
          ENABLE_LOW_ADDR: reg_rdata <= enable_low_q;
          default:         reg_rdata <= 8'h0000;
        endcase
      end
    end
  end

  // ***************************************************************
  // arbitration
  // ***************************************************************
  // R18 - individual enable gates source
  assign eligible = req_low_q & enable_low_q;
  assign win_idx  = top_bit(eligible);
  // R15 - master enable zero blocks maskables; R22 - boundary start
  assign start = insn_boundary && (state_q == ST_IDLE) && !nmi_block_q &&
                 (nmi_pend_q || (iflag && (eligible != 8'h0000)));

  // non-maskable request latch and post-accept block
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend_q  <= 1'b0;
      nmi_block_q <= 1'b0;
    end else if (clk_en) begin
      // R21 - a new event beats acceptance clear
      nmi_pend_q <= nmi_event || (nmi_pend_q && !start);
      // R10 - nmi blocks all later interrupts until return
      if (start && nmi_pend_q) begin
        nmi_block_q <= 1'b1;
      end else if (return_from_interrupt_done) begin
        // R8 - return ends the service
        nmi_block_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // acceptance sequencer
  // ***************************************************************
  // R7 - eight cycles from launch to the opcode fetch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE;
      accept_idx_q <= 3'd0;
      accept_nmi_q <= 1'b0;
      entry_low_q  <= 8'h0000;
      entry_high_q <= 8'h0000;
    end else if (clk_en) begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            // R19 - nmi first, then highest fixed priority
            state_q      <= ST_UNUSED;
            accept_nmi_q <= nmi_pend_q;
            accept_idx_q <= win_idx;
          end
        end
        // R14 - idle cycle, three pushes, vector reads, fetch
        ST_UNUSED: state_q <= ST_PUSH_H;
        ST_PUSH_H: state_q <= ST_PUSH_L;
        ST_PUSH_L: state_q <= ST_PUSH_P;
        ST_PUSH_P: state_q <= ST_VEC_L;
        ST_VEC_L: begin
          // each entry byte is taken in the cycle of its own read
          entry_low_q <= bus_rdata;
          state_q     <= ST_VEC_H;
        end
        ST_VEC_H: begin
          // memory need not hold read data after the read ends
          entry_high_q <= bus_rdata;
          state_q      <= ST_ENTRY;
        end
        ST_ENTRY: state_q <= ST_FETCH;
        ST_FETCH: state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // vector address of the accepted source, two bytes per entry
  logic [15:0] vec_addr;
  always_comb begin
    vec_addr = accept_nmi_q ? VEC_NMI : (VEC_BASE + 16'({12'h0000, accept_idx_q, 1'b0}));
  end

  // bus drive per step; stack sits in page one, hence sp only in low byte
  always_comb begin
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_addr  = 16'h0000;
    bus_wdata = 8'h0000;
    sp_dec    = 1'b0;
    pc_load   = 1'b0;
    unique case (state_q)
      // R12 - push pc high, low, then status
      // R17 - nothing else is saved by hardware
      ST_PUSH_H: begin
        bus_wr = 1'b1; bus_addr = {8'h01, sp_in}; bus_wdata = pc_in[15:8]; sp_dec = 1'b1;
      end
      ST_PUSH_L: begin
        bus_wr = 1'b1; bus_addr = {8'h01, sp_in}; bus_wdata = pc_in[7:0]; sp_dec = 1'b1;
      end
      ST_PUSH_P: begin
        bus_wr = 1'b1; bus_addr = {8'h01, sp_in}; bus_wdata = psw_in; sp_dec = 1'b1;
      end
      // R13 - read entry from vector table
      ST_VEC_L: begin
        bus_rd = 1'b1; bus_addr = vec_addr;
      end
      ST_VEC_H: begin
        bus_rd = 1'b1; bus_addr = vec_addr + 16'h0001;
      end
      ST_ENTRY: begin
        pc_load = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // R13 - entry address loaded into the program counter
  assign pc_out      = {entry_high_q, entry_low_q};
  assign accept_busy = (state_q != ST_IDLE);
  // R9 - master enable cleared on acceptance
  assign iflag_clear = (state_q == ST_UNUSED);

endmodule : interrupt_request_and_acceptance

// ---- testbench/intc_sva.sv ----
`timescale 1ns/1ps
module intc_sva (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        nmi_event,
  input wire logic        insn_boundary,
  input wire logic        iflag,
  input wire logic [15:0] pc_in,
  input wire logic [7:0]  psw_in,
  input wire logic [7:0]  bus_rdata,
  input wire logic        accept_busy,
  input wire logic        iflag_clear,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        sp_dec,
  input wire logic        pc_load,
  input wire logic [15:0] pc_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic nmi_q;  // nmi seen, not yet taken
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      nmi_q <= 1'b0;
    else if (nmi_event)
      nmi_q <= 1'b1;
    else if (iflag_clear)
      nmi_q <= 1'b0;
  end
  sequence s_push; bus_wr && sp_dec && !bus_rd; endsequence
  sequence s_vec; bus_rd && !bus_wr; endsequence
  property p_len; $rose(accept_busy) |-> accept_busy[*8] ##1 !accept_busy; endproperty
  a_len: assert property (p_len) else $error("accept length");
  property p_order; $rose(accept_busy) |-> !bus_wr && !bus_rd
    ##1 s_push[*3] ##1 s_vec[*2] ##1 pc_load; endproperty
  a_order: assert property (p_order) else $error("bus order");
  property p_push; $rose(accept_busy) |-> ##1 bus_wdata == pc_in[15:8]
    ##1 bus_wdata == pc_in[7:0] ##1 bus_wdata == psw_in; endproperty
  a_push: assert property (p_push) else $error("push data");
  property p_clr; $rose(accept_busy) |-> iflag_clear; endproperty
  a_clr: assert property (p_clr) else $error("no iflag clear");
  property p_entry; pc_load |-> pc_out == {$past(bus_rdata), $past(bus_rdata, 2)}; endproperty
  a_entry: assert property (p_entry) else $error("entry load");
  property p_vec; bus_rd && $past(bus_rd) |-> bus_addr == $past(bus_addr) + 16'h0001; endproperty
  a_vec: assert property (p_vec) else $error("vector addr");
  property p_start; $rose(accept_busy) |-> $past(insn_boundary); endproperty
  a_start: assert property (p_start) else $error("start off boundary");
  property p_mask; $rose(accept_busy) |-> $past(iflag) || $past(nmi_q) || $past(nmi_event);
  endproperty
  a_mask: assert property (p_mask) else $error("masked accept");
  property p_rdata; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("stray rdata");
endmodule : intc_sva
bind interrupt_request_and_acceptance intc_sva u_sva (.*);

// ---- testbench/core_model.sv ----
`timescale 1ns/1ps
module core_model (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        ei,
  input  wire logic        iflag_clear,
  input  wire logic        sp_dec,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_out,
  input  wire logic        bus_rd,
  input  wire logic [15:0] bus_addr,
  output logic             iflag,
  output logic      [7:0]  sp_in,
  output logic      [15:0] pc_in,
  output logic      [7:0]  bus_rdata
);
  logic [7:0] last_q;  // last read byte; idle bus shows its inverse
  // vector table: high byte fixed, low byte mirrors address
  assign bus_rdata = bus_rd ? (bus_addr[0] ? 8'hC0 : bus_addr[7:0]) : ~last_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      iflag <= 1'b0;
      sp_in <= 8'hFF;
      pc_in <= 16'h1234;
      last_q <= 8'h00;
    end else begin
      if (iflag_clear)
        iflag <= 1'b0;
      else if (ei)
        iflag <= 1'b1;
      // besides the iflag clear, only sp and pc touched by hardware
      if (sp_dec)
        sp_in <= sp_in - 8'h01;
      if (pc_load)
        pc_in <= pc_out;
      if (bus_rd)
        last_q <= bus_rdata;
    end
  end
endmodule : core_model

// ---- testbench/interrupt_request_and_acceptance_tb.sv ----
`timescale 1ns/1ps
module interrupt_request_and_acceptance_tb;
  import intc_pkg::*;
  typedef struct {logic [7:0] ev; logic [15:0] pc;} row_t;
  row_t rows [7] = '{'{8'h01, 16'hC0E0}, '{8'h04, 16'hC0E4}, '{8'h08, 16'hC0E6},
    '{8'h10, 16'hC0E8}, '{8'h20, 16'hC0EA}, '{8'h40, 16'hC0EC}, '{8'h80, 16'hC0EE}};
  logic        core_clk, reset_n, reg_wr, reg_rd, nmi_event, insn_boundary, return_from_interrupt_done, ei;
  logic        iflag, accept_busy, iflag_clear, bus_wr, bus_rd, sp_dec, pc_load;
  logic [7:0]  reg_addr, reg_wdata, source_event, timer_event, periph_event;
  logic [7:0]  reg_rdata, sp_in, bus_rdata, bus_wdata;
  logic [15:0] pc_in, bus_addr, pc_out;
  logic        clk_en = 1'b1;
  logic [7:0]  psw_in = 8'h5A;
  int          miscompares = 0;
  int          compares = 0;
  interrupt_request_and_acceptance dut (.*);
  core_model core (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask : rd
  task automatic fire(input logic [7:0] ev);
    @(posedge core_clk);
    source_event <= ev;
    @(posedge core_clk);
    source_event <= 8'h00;
  endtask : fire
  task automatic en;
    @(posedge core_clk);
    ei <= 1'b1;
    @(posedge core_clk);
    ei <= 1'b0;
  endtask : en
  // waits for the entry load, then checks pc and an sp drop of three
  task automatic acc(input logic [15:0] e);
    logic [7:0] sp0;
    sp0 = sp_in;
    for (int i = 0; i < 40 && pc_load !== 1'b1; i++) @(negedge core_clk);
    chk(pc_out, e);
    repeat (3) @(negedge core_clk);
    chk(16'(sp_in), 16'(sp0 - 8'h03));
  endtask : acc
  task automatic quiet(input int n);
    logic hit;
    hit = 1'b0;
    repeat (n) @(negedge core_clk) hit |= accept_busy;
    chk(16'(hit), 16'h0000);
  endtask : quiet
  task automatic rst;
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rst
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end
  initial begin
    {reg_wr, reg_rd, nmi_event, return_from_interrupt_done, ei, reset_n} = '0;
    {reg_addr, reg_wdata, source_event, timer_event, periph_event} = '0;
    insn_boundary = 1'b1;
    rst();
    foreach (rows[i]) begin
      wr(ENABLE_LOW_ADDR, rows[i].ev);
      en();
      fire(rows[i].ev);
      acc(rows[i].pc);
      rd(REQ_LOW_ADDR, 8'h00);
    end
    @(posedge core_clk);
    {timer_event, periph_event} <= 16'hFFFF;
    @(posedge core_clk);
    {timer_event, periph_event} <= 16'h0000;
    rd(TIMER_SRC_ADDR, 8'hFF);
    rd(PERIPH_SRC_ADDR, PERIPH_SRC_MASK);
    wr(ENABLE_LOW_ADDR, 8'h01);
    en();
    fire(8'h01);
    acc(16'hC0E0);
    rd(PERIPH_SRC_ADDR, 8'h83);
    wr(PERIPH_SRC_ADDR, 8'h80);
    rd(PERIPH_SRC_ADDR, 8'h80);
    wr(TIMER_SRC_ADDR, 8'h0F);
    rd(TIMER_SRC_ADDR, 8'h0F);
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(TIMER_SRC_ADDR, 8'h00);
    clk_en <= 1'b1;
    rd(TIMER_SRC_ADDR, 8'h0F);
    fire(8'h01);
    quiet(20);
    rd(REQ_LOW_ADDR, 8'h01);
    en();
    acc(16'hC0E0);
    en();
    wr(ENABLE_LOW_ADDR, 8'h00);
    fire(8'h20);
    quiet(20);
    wr(REQ_LOW_ADDR, 8'h00);
    rd(REQ_LOW_ADDR, 8'h00);
    @(posedge core_clk);
    source_event <= 8'h10;
    reg_addr <= REQ_LOW_ADDR;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    source_event <= 8'h00;
    reg_wr <= 1'b0;
    rd(REQ_LOW_ADDR, 8'h10);
    wr(REQ_LOW_ADDR, 8'h00);
    wr(ENABLE_LOW_ADDR, 8'hFF);
    fire(8'h81);
    acc(16'hC0EE);
    rd(REQ_LOW_ADDR, 8'h01);
    wr(REQ_LOW_ADDR, 8'h00);
    fire(8'h02);
    rd(REQ_LOW_ADDR, 8'h00);
    @(posedge core_clk);
    insn_boundary <= 1'b0;
    en();
    fire(8'h01);
    quiet(10);
    @(posedge core_clk);
    insn_boundary <= 1'b1;
    acc(16'hC0E0);
    en();
    @(posedge core_clk);
    nmi_event <= 1'b1;
    @(posedge core_clk);
    nmi_event <= 1'b0;
    acc(16'hC0FE);
    en();
    fire(8'h01);
    quiet(20);
    @(posedge core_clk);
    return_from_interrupt_done <= 1'b1;
    @(posedge core_clk);
    return_from_interrupt_done <= 1'b0;
    acc(16'hC0E0);
    fire(8'h04);
    rst();
    rd(REQ_LOW_ADDR, 8'h00);
    rd(TIMER_SRC_ADDR, 8'h00);
    rd(PERIPH_SRC_ADDR, 8'h00);
    rd(8'h10, 8'h00);
    end_sim();
  end
endmodule : interrupt_request_and_acceptance_tb
